// ===== src/gnlk_pkg.sv
// Package: register map, field layout, reset values and timing of the clock-output block
package gnlk_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_FB_LO = 6'h28;
  localparam logic [5:0] IDX_FB_HI = 6'h29;
  localparam logic [5:0] IDX_REF_LO = 6'h2a;
  localparam logic [5:0] IDX_REF_HI = 6'h2b;
  localparam logic [5:0] IDX_CTL_A = 6'h2c;
  localparam logic [5:0] IDX_CTL_B = 6'h2d;
  localparam logic [5:0] IDX_CTL_D = 6'h2e;
  localparam logic [5:0] IDX_HIZ = 6'h2f;
  localparam logic [5:0] IDX_STATUS = 6'h3e;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int HALF_BIT = 0;
  localparam int QUART_BIT = 1;
  localparam int SKEW_LSB = 2;
  localparam int DRIVE_BIT = 6;
  localparam logic [1:0] HIZ_ON = 2'h3;
  localparam logic [15:0] CTL_AB_MASK = 16'h007f;
  localparam logic [15:0] CTL_D_MASK = 16'h003f;
  localparam logic [15:0] HIZ_MASK = 16'h0003;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [1:0] HIZ_RST = 2'h0;
  localparam logic [2:0] DIVCNT_RST = 3'h0;
  localparam logic [4:0] STABLE_MAX = 5'h1f;

  // ----------------------------------------
  // Ratio defaults per output standard
  // ----------------------------------------
  localparam logic [31:0] NUM_DEF [4] = '{32'h00000010, 32'h00000020,
                                          32'h00000030, 32'h00000040};
  localparam logic [31:0] DEN_DEF [4] = '{32'h00000001, 32'h00000002,
                                          32'h00000003, 32'h00000004};

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PS = 25000;
  localparam int STEP_PS = 700;
  localparam int STEP_CYC = (STEP_PS / CLK_PS) < 1 ? 1 : (STEP_PS / CLK_PS);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [8:0] rsvd;
    logic driveHi;
    logic [3:0] skew;
    logic quarter;
    logic half;
  } gnlk_ctl_t;

  typedef struct packed {
    logic [5:0] idx;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } gnlk_req_t;

endpackage

// ===== src/gnlk_clock_ctrl.sv
// Genlock ratio registers and three divided, skewed video clock outputs
// Function
// - Hold 32-bit genlock feedback numerator
// - Numerator low word 28h, high 29h
// - Hold 32-bit genlock reference denominator
// - Denominator low word 2Ah, high 2Bh
// - Ratio defaults follow selected video standard
// - Output A skew code, reset zero
// - Output B skew code, reset zero
// - Differential output skew code, reset zero
// - Output A bit1 quarter, bit0 half
// - Output A both divider bits: held low
// - Output B bit1 quarter, bit0 half
// - Output B both divider bits: held low
// - Differential bit1 quarter, bit0 half
// - Differential both bits: full-rate clock
// - Hiz field 11b floats differential pair
// - Output A bit 6 selects high drive
`timescale 1ns/1ps
`default_nettype none

module gnlk_clock_ctrl #(
  parameter int HIST = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Selected output standard pins
  input wire logic [1:0] videoStd,
  // Genlock ratio to the loop
  output logic [31:0] fbNumerator,
  output logic [31:0] refDenominator,
  // Clock outputs
  output logic video_clk_out_a,
  output logic video_clk_out_b,
  output logic drive_strength_a,
  output logic drive_strength_b,
  output logic video_clk_out_diff_p,
  output logic video_clk_out_diff_n,
  output logic diffOe
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Raw level of one output from divider state and control word
  function automatic logic rawLevel(
    input gnlk_pkg::gnlk_ctl_t c,
    input logic [2:0] cnt,
    input logic bothFull
  );
    logic r;
    r = 1'b0;
    case ({c.quarter, c.half})
      2'b00: r = cnt[0];
      2'b01: r = cnt[1];
      2'b10: r = cnt[2];
      2'b11: r = bothFull ? cnt[0] : 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Skewed level: code 0 undelayed, code k taps k steps back
  function automatic logic skewTap(
    input logic raw,
    input logic [HIST-1:0] hist,
    input logic [3:0] code
  );
    return (code == 4'h0) ? raw : hist[code - 4'h1];
  endfunction

  // Merge a 16-bit register with write data under byte lanes
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // Bus request
  // ----------------------------------------
  gnlk_pkg::gnlk_req_t req;
  logic reqOn;
  logic wrOn;

  assign req = '{idx: wb_adr_i[7:2], we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
  assign reqOn = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrOn = reqOn && req.we;

  // ----------------------------------------
  // Standard pin synchroniser
  // ----------------------------------------
  logic [1:0] stdMeta_r;
  logic [1:0] stdSync_r;
  logic [1:0] stdLast_r;
  logic loadPend_r;
  logic loadDef;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stdMeta_r <= 2'h0;
      stdSync_r <= 2'h0;
      stdLast_r <= 2'h0;
      loadPend_r <= 1'b1;
    end
    else
    begin
      stdMeta_r <= videoStd;
      stdSync_r <= stdMeta_r;
      stdLast_r <= stdSync_r;
      loadPend_r <= 1'b0;
    end
  end

  assign loadDef = loadPend_r || (stdSync_r != stdLast_r);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] num_r, num_nxt, den_r, den_nxt;
  logic [15:0] ctlA_r, ctlA_nxt, ctlB_r, ctlB_nxt, ctlD_r, ctlD_nxt;
  logic [1:0] hiz_r, hiz_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [2:0] divCnt_r, divCnt_nxt;

  always_comb
  begin
    num_nxt = num_r;
    den_nxt = den_r;
    ctlA_nxt = ctlA_r;
    ctlB_nxt = ctlB_r;
    ctlD_nxt = ctlD_r;
    hiz_nxt = hiz_r;
    ack_nxt = reqOn;
    rd_nxt = 32'h0;
    if (loadDef)
    begin
      num_nxt = gnlk_pkg::NUM_DEF[stdSync_r];
      den_nxt = gnlk_pkg::DEN_DEF[stdSync_r];
    end
    // software ratio writes win over defaults
    if (wrOn)
    begin
      case (req.idx)
        gnlk_pkg::IDX_FB_LO: num_nxt[15:0] = laneMerge(num_r[15:0], req.dat, req.sel);
        gnlk_pkg::IDX_FB_HI: num_nxt[31:16] = laneMerge(num_r[31:16], req.dat, req.sel);
        gnlk_pkg::IDX_REF_LO: den_nxt[15:0] = laneMerge(den_r[15:0], req.dat, req.sel);
        gnlk_pkg::IDX_REF_HI: den_nxt[31:16] = laneMerge(den_r[31:16], req.dat, req.sel);
        gnlk_pkg::IDX_CTL_A:
          ctlA_nxt = laneMerge(ctlA_r, req.dat, req.sel) & gnlk_pkg::CTL_AB_MASK;
        gnlk_pkg::IDX_CTL_B:
          ctlB_nxt = laneMerge(ctlB_r, req.dat, req.sel) & gnlk_pkg::CTL_AB_MASK;
        gnlk_pkg::IDX_CTL_D:
          ctlD_nxt = laneMerge(ctlD_r, req.dat, req.sel) & gnlk_pkg::CTL_D_MASK;
        gnlk_pkg::IDX_HIZ: hiz_nxt = req.sel[0] ? req.dat[1:0] : hiz_r;
        default: ;
      endcase
    end
    if (reqOn && !req.we)
    begin
      case (req.idx)
        gnlk_pkg::IDX_FB_LO: rd_nxt = {16'h0, num_r[15:0]};
        gnlk_pkg::IDX_FB_HI: rd_nxt = {16'h0, num_r[31:16]};
        gnlk_pkg::IDX_REF_LO: rd_nxt = {16'h0, den_r[15:0]};
        gnlk_pkg::IDX_REF_HI: rd_nxt = {16'h0, den_r[31:16]};
        gnlk_pkg::IDX_CTL_A: rd_nxt = {16'h0, ctlA_r};
        gnlk_pkg::IDX_CTL_B: rd_nxt = {16'h0, ctlB_r};
        gnlk_pkg::IDX_CTL_D: rd_nxt = {16'h0, ctlD_r};
        gnlk_pkg::IDX_HIZ: rd_nxt = {30'h0, hiz_r};
        gnlk_pkg::IDX_STATUS: rd_nxt = {27'h0, divCnt_r, stdSync_r};
        default: rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      num_r <= gnlk_pkg::NUM_DEF[0];
      den_r <= gnlk_pkg::DEN_DEF[0];
      ctlA_r <= gnlk_pkg::CTL_RST;
      ctlB_r <= gnlk_pkg::CTL_RST;
      ctlD_r <= gnlk_pkg::CTL_RST;
      hiz_r <= gnlk_pkg::HIZ_RST;
      ack_r <= 1'b0;
      rd_r <= 32'h0;
    end
    else
    begin
      num_r <= num_nxt;
      den_r <= den_nxt;
      ctlA_r <= ctlA_nxt;
      ctlB_r <= ctlB_nxt;
      ctlD_r <= ctlD_nxt;
      hiz_r <= hiz_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign fbNumerator = num_r;
  assign refDenominator = den_r;

  // ----------------------------------------
  // Clock divider and skew lines
  // ----------------------------------------
  gnlk_pkg::gnlk_ctl_t cA, cB, cD;
  logic [HIST-1:0] histA_r, histA_nxt, histB_r, histB_nxt, histD_r, histD_nxt;
  logic rawA, rawB, rawD;
  logic outA_r, outA_nxt, outB_r, outB_nxt, outD_r, outD_nxt, outDn_r, outDn_nxt;
  logic oe_r, oe_nxt;
  logic drvA_r, drvA_nxt, drvB_r, drvB_nxt;

  assign cA = gnlk_pkg::gnlk_ctl_t'(ctlA_r);
  assign cB = gnlk_pkg::gnlk_ctl_t'(ctlB_r);
  assign cD = gnlk_pkg::gnlk_ctl_t'(ctlD_r);

  always_comb
  begin
    divCnt_nxt = divCnt_r + 3'h1;
    rawA = rawLevel(cA, divCnt_r, 1'b0);
    rawB = rawLevel(cB, divCnt_r, 1'b0);
    rawD = rawLevel(cD, divCnt_r, 1'b1);
    histA_nxt = {histA_r[HIST-2:0], rawA};
    histB_nxt = {histB_r[HIST-2:0], rawB};
    histD_nxt = {histD_r[HIST-2:0], rawD};
    outA_nxt = skewTap(rawA, histA_r, cA.skew);
    outB_nxt = skewTap(rawB, histB_r, cB.skew);
    outD_nxt = skewTap(rawD, histD_r, cD.skew);
    outDn_nxt = ~outD_nxt;
    oe_nxt = (hiz_r != gnlk_pkg::HIZ_ON);
    drvA_nxt = cA.driveHi;
    drvB_nxt = cB.driveHi;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      divCnt_r <= gnlk_pkg::DIVCNT_RST;
      histA_r <= '0;
      histB_r <= '0;
      histD_r <= '0;
      outA_r <= 1'b0;
      outB_r <= 1'b0;
      outD_r <= 1'b0;
      outDn_r <= 1'b1;
      oe_r <= 1'b1;
      drvA_r <= 1'b0;
      drvB_r <= 1'b0;
    end
    else
    begin
      divCnt_r <= divCnt_nxt;
      histA_r <= histA_nxt;
      histB_r <= histB_nxt;
      histD_r <= histD_nxt;
      outA_r <= outA_nxt;
      outB_r <= outB_nxt;
      outD_r <= outD_nxt;
      outDn_r <= outDn_nxt;
      oe_r <= oe_nxt;
      drvA_r <= drvA_nxt;
      drvB_r <= drvB_nxt;
    end
  end

  assign video_clk_out_a = outA_r;
  assign video_clk_out_b = outB_r;
  assign video_clk_out_diff_p = outD_r;
  assign video_clk_out_diff_n = outDn_r;
  assign diffOe = oe_r;
  assign drive_strength_a = drvA_r;
  assign drive_strength_b = drvB_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [4:0] stable_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stable_r <= 5'h0;
    end
    else if (ctlA_nxt != ctlA_r || ctlB_nxt != ctlB_r || ctlD_nxt != ctlD_r)
    begin
      stable_r <= 5'h0;
    end
    else if (stable_r != gnlk_pkg::STABLE_MAX)
    begin
      stable_r <= stable_r + 5'h1;
    end
  end

  sequence s_wrIdx(logic [5:0] i);
    wrOn && req.idx == i && req.sel[1:0] == 2'h3;
  endsequence

  property p_numLo;
    @(posedge clk) disable iff (reset)
    s_wrIdx(gnlk_pkg::IDX_FB_LO) |=> num_r[15:0] == $past(wb_dat_i[15:0]);
  endproperty
  a_numLo: assert property (p_numLo) else $error("numerator low word not written");
  property p_denHi;
    @(posedge clk) disable iff (reset)
    s_wrIdx(gnlk_pkg::IDX_REF_HI) |=> den_r[31:16] == $past(wb_dat_i[15:0]);
  endproperty
  a_denHi: assert property (p_denHi) else $error("denominator high word not written");
  property p_numRead;
    @(posedge clk) disable iff (reset)
    reqOn && !req.we && req.idx == gnlk_pkg::IDX_FB_HI && !loadDef
      |=> wb_ack_o && wb_dat_o == {16'h0, num_r[31:16]};
  endproperty
  a_numRead: assert property (p_numRead) else $error("numerator read wrong");
  property p_default;
    @(posedge clk) disable iff (reset)
    stdSync_r != stdLast_r && !wrOn |=> num_r == gnlk_pkg::NUM_DEF[$past(stdSync_r)]
      && den_r == gnlk_pkg::DEN_DEF[$past(stdSync_r)];
  endproperty
  a_default: assert property (p_default) else $error("ratio default not loaded");
  property p_lowA;
    @(posedge clk) disable iff (reset)
    stable_r > 5'h11 && cA.quarter && cA.half |-> !video_clk_out_a;
  endproperty
  a_lowA: assert property (p_lowA) else $error("output A not held low");
  property p_lowB;
    @(posedge clk) disable iff (reset)
    stable_r > 5'h11 && cB.quarter && cB.half |-> !video_clk_out_b;
  endproperty
  a_lowB: assert property (p_lowB) else $error("output B not held low");
  property p_fullD;
    @(posedge clk) disable iff (reset)
    stable_r > 5'h2 && cD.quarter && cD.half && cD.skew == 4'h0
      |-> video_clk_out_diff_p != $past(video_clk_out_diff_p);
  endproperty
  a_fullD: assert property (p_fullD) else $error("diff not full rate");
  property p_halfA;
    @(posedge clk) disable iff (reset)
    stable_r > 5'h4 && {cA.quarter, cA.half} == 2'h1 && cA.skew == 4'h0
      |-> video_clk_out_a == $past(divCnt_r[1]);
  endproperty
  a_halfA: assert property (p_halfA) else $error("output A not half rate");
  property p_skewB;
    @(posedge clk) disable iff (reset)
    stable_r > 5'h13 && {cB.quarter, cB.half} == 2'h1 && cB.skew == 4'h2
      |-> video_clk_out_b == $past(divCnt_r[1], 3);
  endproperty
  a_skewB: assert property (p_skewB) else $error("output B skew wrong");
  property p_hiz;
    @(posedge clk) disable iff (reset)
    hiz_r == gnlk_pkg::HIZ_ON |=> !diffOe ##1 (diffOe == ($past(hiz_r) != gnlk_pkg::HIZ_ON));
  endproperty
  a_hiz: assert property (p_hiz) else $error("diff pair not floated");

endmodule
`default_nettype wire

// ===== test/gnlk_clk_sink.sv
// Downstream clock sink that measures the period of one clock output
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Period meter
// ----------------------------------------
module gnlk_clk_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Observed clock
  input wire logic clkIn,
  // Measurement
  output logic [7:0] period,
  output logic [7:0] idle
);
  logic prev;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prev <= 1'b0;
      period <= 8'h00;
      idle <= 8'h00;
    end
    else
    begin
      prev <= clkIn;
      if (clkIn && !prev)
      begin
        period <= idle + 8'h01;
        idle <= 8'h00;
      end
      else if (idle != 8'hff)
        idle <= idle + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ===== test/test_gnlk_clock_ctrl.sv
// Self-checking bench for the genlock ratio and clock output block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
  end

// ----------------------------------------
// Bench top
// ----------------------------------------
module test_gnlk_clock_ctrl;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [1:0] videoStd = 2'h0;
  logic [31:0] fbNum;
  logic [31:0] refDen;
  logic clkA, clkB, drvA, drvB, diffP, diffN, diffOe;
  logic [7:0] perA, idleA, perB, idleB, perD, idleD;
  logic [15:0] aHist = 16'h0;
  logic [16:0] hh;
  int error_cnt = 0;
  int compares = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) aHist <= {aHist[14:0], clkA};
  assign hh = {aHist, clkA};

  gnlk_clock_ctrl #(.HIST(16)) i_gnlk_clock_ctrl (
    .clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .videoStd(videoStd), .fbNumerator(fbNum), .refDenominator(refDen),
    .video_clk_out_a(clkA), .video_clk_out_b(clkB), .drive_strength_a(drvA),
    .drive_strength_b(drvB), .video_clk_out_diff_p(diffP), .video_clk_out_diff_n(diffN),
    .diffOe(diffOe));

  gnlk_clk_sink i_gnlk_clk_sink_a (.clk(clk), .reset(reset), .clkIn(clkA),
    .period(perA), .idle(idleA));
  gnlk_clk_sink i_gnlk_clk_sink_b (.clk(clk), .reset(reset), .clkIn(clkB),
    .period(perB), .idle(idleB));
  gnlk_clk_sink i_gnlk_clk_sink_d (.clk(clk), .reset(reset), .clkIn(diffP),
    .period(perD), .idle(idleD));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic wbx(input logic [5:0] ix, input logic w, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {ix, 2'b00};
    wbSel <= 4'h3;
    wbDatI <= {16'h0000, d};
    @(posedge clk);
    while (wbAck !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
      error_cnt++;
    q = wbDatO[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] ix, input logic [15:0] d);
    logic [15:0] q;
    wbx(ix, 1'b1, d, q);
  endtask

  task automatic rdChk(input logic [5:0] ix, input logic [15:0] e);
    logic [15:0] q;
    wbx(ix, 1'b0, 16'h0000, q);
    `CHK(q, e)
  endtask

  function automatic int expPer(input int m, input bit diff);
    case (m)
      0: return 2;
      1: return 4;
      2: return 8;
      default: return diff ? 2 : 0;
    endcase
  endfunction

  task automatic perChk(input logic [7:0] per, input logic [7:0] idle, input int e);
    if (e == 0)
      `CHK(idle > 8'd20, 1'b1)
    else
      `CHK(per, e[7:0])
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    logic [1:0] std;
    logic [31:0] num, den;
    int k, k2;
    logic [15:0] q;
    void'($urandom(32'h8d73));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    `CHK(fbNum, gnlk_pkg::NUM_DEF[0])
    rdChk(gnlk_pkg::IDX_CTL_A, 16'h0000);
    rdChk(gnlk_pkg::IDX_CTL_B, 16'h0000);
    rdChk(gnlk_pkg::IDX_CTL_D, 16'h0000);
    rdChk(gnlk_pkg::IDX_HIZ, 16'h0000);
    rdChk(6'h10, 16'h0000);
    std = 2'(1 + $urandom % 3);
    @(posedge clk);
    videoStd <= std;
    repeat (6) @(posedge clk);
    `CHK(fbNum, gnlk_pkg::NUM_DEF[std])
    `CHK(refDen, gnlk_pkg::DEN_DEF[std])
    wbx(gnlk_pkg::IDX_STATUS, 1'b0, 16'h0000, q);
    `CHK({q[15:5], q[1:0]}, {11'h000, std})
    for (int i = 0; i < 4; i++)
    begin
      num = (i == 0) ? 32'hffff0001 : $urandom;
      den = (i == 0) ? 32'h0001ffff : $urandom;
      wr(gnlk_pkg::IDX_FB_LO, num[15:0]);
      wr(gnlk_pkg::IDX_FB_HI, num[31:16]);
      wr(gnlk_pkg::IDX_REF_LO, den[15:0]);
      wr(gnlk_pkg::IDX_REF_HI, den[31:16]);
      rdChk(gnlk_pkg::IDX_FB_HI, num[31:16]);
      rdChk(gnlk_pkg::IDX_REF_LO, den[15:0]);
      `CHK(fbNum, num)
      `CHK(refDen, den)
    end
    for (int m = 0; m < 4; m++)
    begin
      wr(gnlk_pkg::IDX_CTL_A, 16'(m));
      wr(gnlk_pkg::IDX_CTL_B, 16'(m));
      wr(gnlk_pkg::IDX_CTL_D, 16'(m));
      repeat (40) @(negedge clk);
      perChk(perA, idleA, expPer(m, 1'b0));
      perChk(perB, idleB, expPer(m, 1'b0));
      perChk(perD, idleD, expPer(m, 1'b1));
    end
    for (int i = 0; i < 3; i++)
    begin
      k = (i == 0) ? 15 : (i == 1) ? 2 : $urandom % 16;
      k2 = (i == 0) ? 0 : $urandom % 16;
      wr(gnlk_pkg::IDX_CTL_A, 16'h0001);
      wr(gnlk_pkg::IDX_CTL_B, {10'h000, k[3:0], 2'b01});
      wr(gnlk_pkg::IDX_CTL_D, {10'h000, k2[3:0], 2'b01});
      repeat (40) @(negedge clk);
      repeat (16)
      begin
        @(negedge clk);
        `CHK(clkB, hh[k])
        `CHK(diffP, hh[k2])
        `CHK(diffN, ~hh[k2])
      end
    end
    wr(gnlk_pkg::IDX_CTL_A, 16'h0040);
    wr(gnlk_pkg::IDX_CTL_B, 16'h0040);
    repeat (3) @(negedge clk);
    `CHK(drvA, 1'b1)
    `CHK(drvB, 1'b1)
    rdChk(gnlk_pkg::IDX_CTL_A, 16'h0040);
    wr(gnlk_pkg::IDX_HIZ, 16'h0003);
    repeat (3) @(negedge clk);
    `CHK(diffOe, 1'b0)
    rdChk(gnlk_pkg::IDX_HIZ, 16'h0003);
    wr(gnlk_pkg::IDX_HIZ, 16'h0002);
    repeat (3) @(negedge clk);
    `CHK(diffOe, 1'b1)
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    `CHK({drvA, drvB, diffOe, diffN}, 4'b0011)
    rdChk(gnlk_pkg::IDX_HIZ, 16'h0000);
    finish_test();
  end

  initial
  begin
    #250000;
    error_cnt++;
    finish_test();
  end
endmodule

`default_nettype wire
